// *** pkg/ebpm_map.svh ***
// Constants for the external bus pin multiplexer
`ifndef EBPM_MAP_SVH
`define EBPM_MAP_SVH
`define EBPM_DATA_W 32
`define EBPM_ADDR_W 26
`define EBPM_SYS_W 32
`define EBPM_CARD_BASE4 4'h5
`define EBPM_CARD_BASE5 4'h6
`define EBPM_MODE_HI 23
`define EBPM_MODE_LO 21
`define EBPM_RNW_BIT 25
`define EBPM_SEL_W 5
`define EBPM_FLOAT_W 4
`define EBPM_PU_LOW_W 16
`endif

// *** pkg/ebpm_pkg.sv ***
// Types for the external bus pin multiplexer
package ebpm_pkg;
  typedef enum logic [2:0] {
    EBPM_CARD_ATTR = 3'h0,
    EBPM_CARD_COMMON = 3'h2,
    EBPM_CARD_IO = 3'h4,
    EBPM_CARD_DISK = 3'h6,
    EBPM_CARD_DISK_ALT = 3'h7
  } ebpm_card_mode_t;
  typedef enum logic [1:0] {
    EBPM_OWN_IDLE = 2'b00,
    EBPM_OWN_STATIC = 2'b01,
    EBPM_OWN_FLOAT = 2'b11,
    EBPM_OWN_SDRAM = 2'b10
  } ebpm_owner_t;
endpackage

// *** design/ebpm_card_decode.sv ***
// Card access decoder: mode and strobe steering
`timescale 1ns/1ps
`include "ebpm_map.svh"
module ebpm_card_decode
  import ebpm_pkg::*;
(
  // Access
  input wire logic [`EBPM_SYS_W-1:0] sys_addr,
  input wire logic card_enable_cs4,
  input wire logic card_enable_cs5,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  // Decode
  output logic card_hit,
  output logic card_memory_output_enable,
  output logic card_memory_write_enable,
  output logic card_io_read,
  output logic card_io_write
);
  ebpm_card_mode_t mode;
  logic io_like;
  always_comb begin
    card_hit = (card_enable_cs4 && sys_addr[31:28] == `EBPM_CARD_BASE4) ||
               (card_enable_cs5 && sys_addr[31:28] == `EBPM_CARD_BASE5);
    mode = ebpm_card_mode_t'(sys_addr[`EBPM_MODE_HI:`EBPM_MODE_LO]);
    io_like = (mode == EBPM_CARD_IO) || (mode == EBPM_CARD_DISK) || (mode == EBPM_CARD_DISK_ALT);
    // Disk modes keep memory output enable asserted low, as in disk emulation
    card_memory_output_enable = io_like ? ((mode == EBPM_CARD_IO) ? 1'b1 : 1'b0) : read_strobe_n;
    card_memory_write_enable = io_like ? 1'b1 : write_strobe_n;
    card_io_read = io_like ? read_strobe_n : 1'b1;
    card_io_write = io_like ? write_strobe_n : 1'b1;
  end
endmodule

// *** design/ebpm_top.sv ***
// External bus pin multiplexer sharing pins among memory controllers
// Operation
// - Share 32 data, 26 address and control pins by requested memory area.
// - Hold address and output controls stable while no access runs.
// - Wait outgoing controller float time before another drives data.
// - SDRAM refresh never delays static controller accesses.
// - Pull-ups on data lines 0 to 15 enabled after reset.
// - Pull-up disable bit switches off pull-ups on data 0 to 15.
// - Card logic driven on chip selects 4/5, only when enabled.
// - Chip-select 4 card space is 0x50000000 to 0x5fffffff.
// - Chip-select 5 card space is 0x60000000 to 0x6fffffff.
// - Card supports attribute, common, I/O and disk-emulation modes.
// - Card 16-bit I/O indication and ATA-select are not handled.
// - Address pin 25 carries card read-not-write during card accesses.
// - NAND command and address latches come from ordinary address bits.
// - Address bits 23..21 select card mode.
// - I/O modes use io strobes, memory modes use memory strobes.
`timescale 1ns/1ps
`include "ebpm_map.svh"
module ebpm_top
  import ebpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration
  input wire logic card_enable_cs4,
  input wire logic card_enable_cs5,
  input wire logic data_bus_pullup_disable,
  input wire logic [`EBPM_FLOAT_W-1:0] static_float_cycles,
  input wire logic [`EBPM_FLOAT_W-1:0] sdram_float_cycles,
  // Static memory controller side
  input wire logic smc_req,
  input wire logic [`EBPM_SYS_W-1:0] smc_sys_addr,
  input wire logic [`EBPM_ADDR_W-1:0] smc_addr,
  input wire logic [7:0] smc_cs_n,
  input wire logic smc_rd_n,
  input wire logic [3:0] smc_wr_n,
  input wire logic smc_nand_oe_n,
  input wire logic smc_nand_we_n,
  input wire logic smc_nand_sel,
  input wire logic [`EBPM_DATA_W-1:0] smc_wdata,
  input wire logic smc_wdata_en,
  output logic smc_grant,
  // SDRAM controller side
  input wire logic sdc_req,
  input wire logic sdc_refresh,
  input wire logic [`EBPM_ADDR_W-1:0] sdc_addr,
  input wire logic sdc_cs_n,
  input wire logic [3:0] sdc_dqm,
  input wire logic [`EBPM_DATA_W-1:0] sdc_wdata,
  input wire logic sdc_wdata_en,
  output logic sdc_grant,
  // External pins
  output logic [`EBPM_ADDR_W-1:0] ext_addr,
  output logic [`EBPM_DATA_W-1:0] ext_data_out,
  output logic ext_data_oe_n,
  output logic [7:0] ext_cs_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic write_byte1_or_select1_n,
  output logic write_byte3_or_select3_n,
  output logic card_enable_low,
  output logic card_enable_high,
  output logic [`EBPM_PU_LOW_W-1:0] data_pullup_en
);
  ebpm_owner_t owner, next_owner;
  ebpm_owner_t pend, next_pend;
  logic [`EBPM_FLOAT_W-1:0] float_cnt, next_float_cnt;
  logic [`EBPM_ADDR_W-1:0] next_ext_addr;
  logic [`EBPM_DATA_W-1:0] next_ext_data_out;
  logic [7:0] next_ext_cs_n;
  logic next_data_oe_n, next_rd_n, next_wr_n, next_b1_n, next_b3_n, next_ce1, next_ce2;
  logic [`EBPM_PU_LOW_W-1:0] next_pullup;
  logic card_hit, c_oe, c_we, c_ior, c_iow;

  ebpm_card_decode u_card (
    .sys_addr(smc_sys_addr),
    .card_enable_cs4(card_enable_cs4),
    .card_enable_cs5(card_enable_cs5),
    .read_strobe_n(smc_rd_n),
    .write_strobe_n(smc_wr_n[0]),
    .card_hit(card_hit),
    .card_memory_output_enable(c_oe),
    .card_memory_write_enable(c_we),
    .card_io_read(c_ior),
    .card_io_write(c_iow)
  );

  // Ownership: refresh stays inside the SDRAM controller, so only sdc_req claims pins
  always_comb begin
    next_owner = owner;
    next_pend = pend;
    next_float_cnt = float_cnt;
    case (owner)
      EBPM_OWN_IDLE: begin
        if (smc_req) begin
          next_owner = EBPM_OWN_STATIC;
        end else if (sdc_req) begin
          next_owner = EBPM_OWN_SDRAM;
        end
      end
      EBPM_OWN_STATIC: begin
        if (!smc_req) begin
          next_owner = EBPM_OWN_FLOAT;
          next_pend = sdc_req ? EBPM_OWN_SDRAM : EBPM_OWN_IDLE;
          next_float_cnt = static_float_cycles;
        end
      end
      EBPM_OWN_SDRAM: begin
        if (!sdc_req) begin
          next_owner = EBPM_OWN_FLOAT;
          next_pend = smc_req ? EBPM_OWN_STATIC : EBPM_OWN_IDLE;
          next_float_cnt = sdram_float_cycles;
        end
      end
      EBPM_OWN_FLOAT: begin
        if (float_cnt == '0) begin
          next_owner = pend;
        end else begin
          next_float_cnt = float_cnt - 1'b1;
        end
      end
      default: next_owner = EBPM_OWN_IDLE;
    endcase
  end

  // Pin values; idle keeps the last address and inactive strobes
  always_comb begin
    next_ext_addr = ext_addr;
    next_ext_data_out = ext_data_out;
    next_ext_cs_n = 8'hff;
    next_data_oe_n = 1'b1;
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    next_b1_n = 1'b1;
    next_b3_n = 1'b1;
    next_ce1 = 1'b1;
    next_ce2 = 1'b1;
    next_pullup = data_bus_pullup_disable ? '0 : '1;
    case (next_owner)
      EBPM_OWN_STATIC: begin
        next_ext_addr = smc_addr;
        next_ext_data_out = smc_wdata;
        next_data_oe_n = !smc_wdata_en;
        next_ext_cs_n = smc_cs_n;
        if (smc_nand_sel) begin
          next_ext_cs_n[6] = smc_nand_oe_n;
          next_ext_cs_n[7] = smc_nand_we_n;
        end
        if (card_hit) begin
          next_ext_addr[`EBPM_RNW_BIT] = smc_wr_n[0];
          next_rd_n = c_oe;
          next_wr_n = c_we;
          next_b1_n = c_ior;
          next_b3_n = c_iow;
          // Byte selects drive the card enables; no 16-bit I/O or ATA-select path exists
          next_ce1 = smc_wr_n[2];
          next_ce2 = smc_wr_n[1];
        end else begin
          next_rd_n = smc_rd_n;
          next_wr_n = smc_wr_n[0];
          next_b1_n = smc_wr_n[1];
          next_b3_n = smc_wr_n[3];
        end
      end
      EBPM_OWN_SDRAM: begin
        next_ext_addr = sdc_addr;
        next_ext_data_out = sdc_wdata;
        next_data_oe_n = !sdc_wdata_en;
        next_ext_cs_n[1] = sdc_cs_n;
        next_b1_n = sdc_dqm[1];
        next_b3_n = sdc_dqm[3];
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      owner <= EBPM_OWN_IDLE;
      pend <= EBPM_OWN_IDLE;
      float_cnt <= '0;
      ext_addr <= '0;
      ext_data_out <= '0;
      ext_data_oe_n <= 1'b1;
      ext_cs_n <= 8'hff;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      write_byte1_or_select1_n <= 1'b1;
      write_byte3_or_select3_n <= 1'b1;
      card_enable_low <= 1'b1;
      card_enable_high <= 1'b1;
      data_pullup_en <= '1;
      smc_grant <= 1'b0;
      sdc_grant <= 1'b0;
    end else begin
      owner <= next_owner;
      pend <= next_pend;
      float_cnt <= next_float_cnt;
      ext_addr <= next_ext_addr;
      ext_data_out <= next_ext_data_out;
      ext_data_oe_n <= next_data_oe_n;
      ext_cs_n <= next_ext_cs_n;
      read_strobe_n <= next_rd_n;
      write_strobe_n <= next_wr_n;
      write_byte1_or_select1_n <= next_b1_n;
      write_byte3_or_select3_n <= next_b3_n;
      card_enable_low <= next_ce1;
      card_enable_high <= next_ce2;
      data_pullup_en <= next_pullup;
      smc_grant <= (next_owner == EBPM_OWN_STATIC);
      sdc_grant <= (next_owner == EBPM_OWN_SDRAM);
    end
  end

  sequence s_static_release;
    owner == EBPM_OWN_STATIC && !smc_req;
  endsequence

  sequence s_pins_floated;
    ext_data_oe_n && !sdc_grant && !smc_grant;
  endsequence

  property p_float_gap;
    @(posedge clk) disable iff (!rstn)
    s_static_release |=> s_pins_floated ##0 (float_cnt == $past(static_float_cycles));
  endproperty
  a_float_gap: assert property (p_float_gap) else $error("data handed over without float gap");

  property p_float_hold;
    @(posedge clk) disable iff (!rstn)
    (owner == EBPM_OWN_FLOAT && float_cnt != '0) |=> s_pins_floated;
  endproperty
  a_float_hold: assert property (p_float_hold) else $error("pins granted before float time ran out");

  property p_idle_stable;
    @(posedge clk) disable iff (!rstn)
    (owner == EBPM_OWN_IDLE && next_owner == EBPM_OWN_IDLE) |=> $stable(ext_addr) && read_strobe_n;
  endproperty
  a_idle_stable: assert property (p_idle_stable) else $error("address moved while idle");

  property p_pullup;
    @(posedge clk) disable iff (!rstn)
    data_bus_pullup_disable |=> data_pullup_en == '0;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-ups not disabled");

  property p_sdram_grant;
    @(posedge clk) disable iff (!rstn)
    (owner == EBPM_OWN_IDLE && !smc_req && sdc_req) |=> sdc_grant ##0 !smc_grant;
  endproperty
  a_sdram_grant: assert property (p_sdram_grant) else $error("sdram not granted from idle");

  property p_dqm1;
    @(posedge clk) disable iff (!rstn)
    (next_owner == EBPM_OWN_SDRAM) |=> write_byte1_or_select1_n == $past(sdc_dqm[1]);
  endproperty
  a_dqm1: assert property (p_dqm1) else $error("byte mask 1 not on shared pin");

  property p_card_rnw;
    @(posedge clk) disable iff (!rstn)
    (next_owner == EBPM_OWN_STATIC && card_hit) |=> ext_addr[`EBPM_RNW_BIT] == $past(smc_wr_n[0]);
  endproperty
  a_card_rnw: assert property (p_card_rnw) else $error("read-not-write missing on pin 25");

  property p_no_card_off;
    @(posedge clk) disable iff (!rstn)
    (next_owner == EBPM_OWN_STATIC && !card_enable_cs4 && !card_enable_cs5) |=>
      (read_strobe_n == $past(smc_rd_n)) && card_enable_low;
  endproperty
  a_no_card_off: assert property (p_no_card_off) else $error("card hit while disabled");

  property p_io_mode;
    @(posedge clk) disable iff (!rstn)
    (next_owner == EBPM_OWN_STATIC && card_hit && smc_sys_addr[23:21] == 3'h4) |=> write_strobe_n;
  endproperty
  a_io_mode: assert property (p_io_mode) else $error("memory write active in io mode");
endmodule

// *** verification/ebpm_ext_mem.sv ***
// Far-side memory model that latches what is written on the shared pins
`timescale 1ns/1ps
`include "ebpm_map.svh"
module ebpm_ext_mem (
  // Pins seen by the memory
  input wire logic clk,
  input wire logic [`EBPM_DATA_W-1:0] ext_data_out,
  input wire logic ext_data_oe_n,
  input wire logic write_strobe_n,
  // Observed value
  output logic [`EBPM_DATA_W-1:0] last_wdata
);
  // Only a driven bus is taken; a floating bus would be noise
  always @(posedge clk) begin
    if (!ext_data_oe_n && !write_strobe_n) begin
      last_wdata <= ext_data_out;
    end
  end
endmodule

// *** verification/ebpm_top_test.sv ***
// Self-checking bench for the external bus pin multiplexer
`timescale 1ns/1ps
`include "ebpm_map.svh"
module ebpm_top_test;
  import ebpm_pkg::*;
  logic clk, rstn, ce4, ce5, pu_dis, smc_req, smc_rd_n, smc_we, sdc_req, sdc_refresh, sdc_cs_n;
  logic [3:0] sf, df, smc_wr_n, sdc_dqm;
  logic [7:0] smc_cs_n, ext_cs_n, cs_exp;
  logic [31:0] smc_sys_addr, smc_wdata, sdc_wdata, ext_data_out, mem_w, seed;
  logic [25:0] smc_addr, sdc_addr, ext_addr, hold_addr;
  logic smc_grant, sdc_grant, oe_n, rd_n, wr_n, b1_n, b3_n;
  logic nand_sel, nand_oe_n, nand_we_n, sdc_we, ce_lo, ce_hi;
  logic [15:0] pull;
  ebpm_card_mode_t modes [5];
  int err_total, samples_checked, gap;
  ebpm_top uut (.clk(clk), .rstn(rstn), .card_enable_cs4(ce4), .card_enable_cs5(ce5),
    .data_bus_pullup_disable(pu_dis), .static_float_cycles(sf), .sdram_float_cycles(df),
    .smc_req(smc_req), .smc_sys_addr(smc_sys_addr), .smc_addr(smc_addr), .smc_cs_n(smc_cs_n),
    .smc_rd_n(smc_rd_n), .smc_wr_n(smc_wr_n), .smc_nand_oe_n(nand_oe_n), .smc_nand_we_n(nand_we_n),
    .smc_nand_sel(nand_sel), .smc_wdata(smc_wdata), .smc_wdata_en(smc_we), .smc_grant(smc_grant),
    .sdc_req(sdc_req), .sdc_refresh(sdc_refresh), .sdc_addr(sdc_addr), .sdc_cs_n(sdc_cs_n),
    .sdc_dqm(sdc_dqm), .sdc_wdata(sdc_wdata), .sdc_wdata_en(sdc_we), .sdc_grant(sdc_grant),
    .ext_addr(ext_addr), .ext_data_out(ext_data_out), .ext_data_oe_n(oe_n), .ext_cs_n(ext_cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .write_byte1_or_select1_n(b1_n),
    .write_byte3_or_select3_n(b3_n), .card_enable_low(ce_lo), .card_enable_high(ce_hi), .data_pullup_en(pull));
  ebpm_ext_mem mem (.clk(clk), .ext_data_out(ext_data_out), .ext_data_oe_n(oe_n),
    .write_strobe_n(wr_n), .last_wdata(mem_w));
  always #2 clk = ~clk;
  function automatic logic [15:0] exp_pull(input logic dis);
    return dis ? 16'h0000 : 16'hffff;
  endfunction
  // Memory strobes only in memory modes; disk modes hold output enable low
  function automatic logic exp_oe(input ebpm_card_mode_t m, input logic rd);
    return (m == EBPM_CARD_IO) ? 1'b1 : (m[2] ? 1'b0 : rd);
  endfunction
  function automatic logic exp_we(input ebpm_card_mode_t m, input logic wr);
    return m[2] ? 1'b1 : wr;
  endfunction
  function automatic logic exp_ior(input ebpm_card_mode_t m, input logic rd);
    return m[2] ? rd : 1'b1;
  endfunction
  function automatic logic exp_iow(input ebpm_card_mode_t m, input logic wr);
    return m[2] ? wr : 1'b1;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_on(input logic sd, input logic lvl);
    gap = 0;
    while (((sd ? sdc_grant : smc_grant) !== lvl) && gap < 40) begin
      @(negedge clk);
      gap++;
    end
    if (gap >= 40) begin
      $display("ERROR grant expected %b seen timeout", lvl);
      err_total++;
      summarize();
    end
  endtask
  initial begin
    modes = '{EBPM_CARD_ATTR, EBPM_CARD_COMMON, EBPM_CARD_IO, EBPM_CARD_DISK, EBPM_CARD_DISK_ALT};
    seed = 32'he5bc53a8;
    {clk, rstn, ce4, ce5, pu_dis, smc_req, sdc_req, sdc_refresh, smc_we, nand_sel, sdc_we} = '0;
    {smc_rd_n, sdc_cs_n, smc_wr_n, smc_cs_n, sdc_dqm, nand_oe_n, nand_we_n} = '1;
    {smc_sys_addr, smc_wdata, sdc_wdata, smc_addr, sdc_addr} = '0;
    sf = 4'h5;
    df = 4'h3;
    err_total = 0;
    samples_checked = 0;
    tick(2);
    chk("pullup_rst", 32'h0000ffff, pull);
    chk("cs_rst", 32'h000000ff, ext_cs_n);
    rstn = 1'b1;
    pu_dis = 1'b1;
    tick(2);
    chk("pullup_off", exp_pull(1'b1), pull);
    pu_dis = 1'b0;
    tick(2);
    chk("pullup_on", exp_pull(1'b0), pull);
    $display("pullup test done");
    smc_sys_addr = 32'h10000000;
    for (int i = 0; i < 6; i++) begin
      smc_addr = 26'($random(seed));
      smc_wdata = $random(seed);
      {smc_we, smc_wr_n, smc_req} = {1'b1, 4'h0, 1'b1};
      wait_on(1'b0, 1'b1);
      tick(1);
      chk("addr", 32'(smc_addr), 32'(ext_addr));
      chk("data", smc_wdata, ext_data_out);
      chk("oe", 32'h0, 32'(oe_n));
      tick(1);
      chk("mem", smc_wdata, mem_w);
      {smc_we, smc_wr_n, smc_req} = {1'b0, 4'hf, 1'b0};
      wait_on(1'b0, 1'b0);
      tick(2);
      hold_addr = ext_addr;
      smc_addr = ~smc_addr;
      tick(3);
      chk("idle_addr", 32'(hold_addr), 32'(ext_addr));
      chk("idle_rd", 32'h1, 32'(rd_n));
    end
    $display("static test done");
    smc_req = 1'b1;
    wait_on(1'b0, 1'b1);
    sdc_addr = 26'($random(seed));
    sdc_dqm = 4'($random(seed));
    sdc_wdata = $random(seed);
    sdc_we = 1'b1;
    {sdc_req, sdc_cs_n, smc_req} = 3'b100;
    wait_on(1'b1, 1'b1);
    chk("float", 32'(sf) + 32'd2, 32'(gap));
    tick(1);
    chk("sddata", sdc_wdata, ext_data_out);
    chk("sdoe", 32'h0, 32'(oe_n));
    chk("dqm1", 32'(sdc_dqm[1]), 32'(b1_n));
    chk("dqm3", 32'(sdc_dqm[3]), 32'(b3_n));
    chk("sdcs", 32'h0, 32'(ext_cs_n[1]));
    chk("sdaddr", 32'(sdc_addr), 32'(ext_addr));
    {sdc_req, sdc_cs_n, sdc_refresh, sdc_we} = 4'b0110;
    wait_on(1'b1, 1'b0);
    chk("float_oe", 32'h1, 32'(oe_n));
    tick(int'(df) + 2);
    smc_req = 1'b1;
    wait_on(1'b0, 1'b1);
    chk("refresh", 32'h1, 32'(gap));
    $display("handover test done");
    for (int k = 0; k < 4; k++) begin
      {ce5, ce4} = (k == 2) ? 2'b00 : ((k == 3) ? 2'b01 : 2'b11);
      for (int m = 0; m < 5; m++) begin
        {nand_sel, nand_oe_n, nand_we_n, smc_rd_n, smc_wr_n} = 8'($random(seed));
        smc_cs_n = 8'($random(seed));
        smc_sys_addr = {k[0] ? 4'h6 : 4'h5, 4'h0, modes[m], 21'h0};
        cs_exp = nand_sel ? {nand_we_n, nand_oe_n, smc_cs_n[5:0]} : smc_cs_n;
        tick(2);
        chk("cs_pins", 32'(cs_exp), 32'(ext_cs_n));
        if (k >= 2) begin
          chk("rd_plain", 32'(smc_rd_n), 32'(rd_n));
          chk("b1_plain", 32'(smc_wr_n[1]), 32'(b1_n));
          chk("b3_plain", 32'(smc_wr_n[3]), 32'(b3_n));
          chk("ce_plain", 32'h3, 32'({ce_hi, ce_lo}));
          chk("a25_plain", 32'(smc_addr[25]), 32'(ext_addr[25]));
        end else begin
          chk("card_oe", 32'(exp_oe(modes[m], smc_rd_n)), 32'(rd_n));
          chk("card_we", 32'(exp_we(modes[m], smc_wr_n[0])), 32'(wr_n));
          chk("card_ior", 32'(exp_ior(modes[m], smc_rd_n)), 32'(b1_n));
          chk("card_iow", 32'(exp_iow(modes[m], smc_wr_n[0])), 32'(b3_n));
          chk("card_ce", 32'({smc_wr_n[1], smc_wr_n[2]}), 32'({ce_hi, ce_lo}));
          chk("card_rnw", 32'(smc_wr_n[0]), 32'(ext_addr[25]));
        end
      end
    end
    $display("card test done");
    summarize();
  end
endmodule
